// file: pas_capture.sv
// Capture end: drives static config, buffers sample words
`timescale 1ns/1ns
module pas_capture #(
  parameter int DATA_W = pas_pkg::DATA_W,
  parameter int DEPTH = pas_pkg::FIFO_DEPTH,
  parameter int LATENCY = pas_pkg::LATENCY
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Static configuration request
  input wire logic cfg_range_2v,
  input wire logic cfg_ref_external,
  input wire logic cfg_drive_en,
  // Sample stream out
  output logic out_valid,
  input wire logic out_ready,
  output logic [DATA_W-1:0] out_data,
  output logic overflow,
  // Link
  pas_link_if.capt link
);
  // The capture register adds one edge to the link latency
  localparam int WARM = LATENCY + 1;
  localparam int CW = $clog2(WARM + 1);
  logic [CW-1:0] warm_r;
  logic [DATA_W-1:0] word_r;
  logic word_vld_r;
  logic fifo_ready;
  logic ovf_r;

  // Levels held static; caller changes them only when idle
  assign link.range_select_pin = cfg_range_2v;
  assign link.reference_source_pin = cfg_ref_external;
  assign link.range_select_oe = cfg_drive_en;
  assign link.reference_source_oe = cfg_drive_en;

  // Words before the pipeline fills are discarded
  always_ff @(posedge clock) begin
    if (rst) begin
      warm_r <= '0;
    end else if (warm_r != CW'(WARM)) begin
      warm_r <= warm_r + 1'b1;
    end
  end

  // Capture on the rising edge after the one the word became valid at
  always_ff @(posedge clock) begin
    if (rst) begin
      word_r <= '0;
      word_vld_r <= 1'b0;
    end else begin
      word_r <= link.sample_word;
      word_vld_r <= (warm_r == CW'(WARM));
    end
  end

  // Converter cannot stall; a full buffer loses the word
  always_ff @(posedge clock) begin
    if (rst) begin
      ovf_r <= 1'b0;
    end else if (word_vld_r && !fifo_ready) begin
      ovf_r <= 1'b1;
    end
  end
  assign overflow = ovf_r;

  pas_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(word_vld_r),
    .in_ready(fifo_ready),
    .in_data(word_r),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );
endmodule

// file: pas_converter.sv
// Converter end: six-stage pipeline, error correction, word output
`timescale 1ns/1ns
// Overview of operation
// - Eight-bit parallel word, MSB first bit
// - Range pin high 2V, low 1V
// - Reference pin high external, low internal
// - New word valid at rising clock edge
// - Result appears four clocks after sampling
// - Six stages, error correction, no missing codes
// - Open pins default to 2V, external
module pas_converter #(
  parameter int DATA_W = pas_pkg::DATA_W,
  parameter int STAGES = pas_pkg::STAGE_COUNT,
  parameter int LATENCY = pas_pkg::LATENCY
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Digitised analog sample, offset binary, taken each edge
  input wire logic [DATA_W-1:0] sample_in,
  // Active configuration seen by the analog side
  output logic range_2v,
  output logic ref_external,
  // Link
  pas_link_if.conv link
);
  // Bits settled by each stage; later stages only carry what is left
  localparam int SLICE = pas_pkg::RESID_W;

  // Register ranks between the sampling edge and the output register
  localparam int RANKS = LATENCY;

  // Digits handed to correction, plus the still-unresolved remainder
  typedef struct packed {
    logic [STAGES-1:0][DATA_W-1:0] digit;
    logic [DATA_W-1:0] rem;
  } pas_stage_t;

  // Idle rank still sums to mid scale, so no glitch follows reset
  localparam pas_stage_t RANK_IDLE = '{
    digit: '0,
    rem: pas_pkg::CODE_MID
  };

  pas_stage_t rank_r [RANKS];
  logic range_r;
  logic ref_r;
  logic output_bit_msb;
  logic output_bit_lsb;
  logic [DATA_W-1:0] code_final;
  logic [DATA_W-1:0] word_nxt;

  // Undriven pin floats high through the pull-up
  function automatic logic pin_level(input logic drv, input logic oe);
    return oe ? drv : 1'b1;
  endfunction

  // Remainder bits still open once stage idx has settled its slice
  function automatic logic [DATA_W-1:0] open_mask(input int idx);
    int open_bits;
    open_bits = DATA_W - (idx + 1) * SLICE;
    if (open_bits <= 0) begin
      return '0;
    end
    return DATA_W'((64'(1) << open_bits) - 64'(1));
  endfunction

  // One stage: hand its slice to correction, pass the rest on.
  // The last stage takes all that is left, whatever the slice width.
  function automatic pas_stage_t stage_step(input pas_stage_t cur,
      input int idx);
    pas_stage_t nxt;
    logic [DATA_W-1:0] keep;
    nxt = cur;
    if (idx >= STAGES - 1) begin
      keep = '0;
    end else begin
      keep = open_mask(idx);
    end
    nxt.digit[idx] = cur.rem & ~keep;
    nxt.rem = cur.rem & keep;
    return nxt;
  endfunction

  // Rank that hosts a stage: stages spread evenly over the ranks
  function automatic int rank_of(input int idx);
    return (idx * RANKS) / STAGES;
  endfunction

  // Apply every stage hosted by rank r, in stage order
  function automatic pas_stage_t run_rank(input pas_stage_t cur,
      input int r);
    pas_stage_t acc;
    acc = cur;
    for (int s = 0; s < STAGES; s++) begin
      if (rank_of(s) == r) begin
        acc = stage_step(acc, s);
      end
    end
    return acc;
  endfunction

  // Fresh sample enters with no digit settled yet
  function automatic pas_stage_t load_sample(input logic [DATA_W-1:0] s);
    pas_stage_t fresh;
    fresh.digit = '0;
    fresh.rem = s;
    return fresh;
  endfunction

  // Error correction: digits cover disjoint bit slices, so their sum
  // reaches every code. Any unsettled remainder is added, not dropped.
  function automatic logic [DATA_W-1:0] correct(input pas_stage_t st);
    logic [DATA_W-1:0] sum;
    sum = st.rem;
    for (int s = 0; s < STAGES; s++) begin
      sum = sum + st.digit[s];
    end
    return sum;
  endfunction

  // Range pin, sampled every edge
  always_ff @(posedge clock) begin
    if (rst) begin
      range_r <= pas_pkg::RANGE_2V;
    end else begin
      range_r <= pin_level(link.range_select_pin,
        link.range_select_oe);
    end
  end

  // Reference pin, sampled every edge
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_r <= pas_pkg::REF_EXTERNAL;
    end else begin
      ref_r <= pin_level(link.reference_source_pin,
        link.reference_source_oe);
    end
  end

  assign range_2v = range_r;
  assign ref_external = ref_r;

  // Stage pipeline: rank 0 takes the sample, the last rank completes
  // the code. Stage count and latency are independent this way.
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int r = 0; r < RANKS; r++) begin
        rank_r[r] <= RANK_IDLE;
      end
    end else begin
      rank_r[0] <= run_rank(load_sample(sample_in), 0);
      for (int r = 1; r < RANKS; r++) begin
        rank_r[r] <= run_rank(rank_r[r-1], r);
      end
    end
  end

  assign code_final = correct(rank_r[RANKS-1]);

  // MSB leads the word, LSB closes it
  assign output_bit_msb = code_final[DATA_W-1];
  assign output_bit_lsb = code_final[0];
  assign word_nxt = {output_bit_msb, code_final[DATA_W-2:1],
    output_bit_lsb};

  // Word register adds the edge that makes the latency four
  always_ff @(posedge clock) begin
    if (rst) begin
      link.sample_word <= pas_pkg::CODE_MID;
    end else begin
      link.sample_word <= word_nxt;
    end
  end
endmodule

// file: pas_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module pas_fifo #(
  parameter int WIDTH = pas_pkg::DATA_W,
  parameter int DEPTH = pas_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_ptr_r];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// file: pas_link_if.sv
// Parallel sample link between converter and capture logic
`timescale 1ns/1ns
interface pas_link_if;
  logic [pas_pkg::DATA_W-1:0] sample_word;
  logic range_select_pin;
  logic reference_source_pin;
  logic range_select_oe;
  logic reference_source_oe;
  modport conv (
    output sample_word,
    input range_select_pin,
    input reference_source_pin,
    input range_select_oe,
    input reference_source_oe
  );
  modport capt (
    input sample_word,
    output range_select_pin,
    output reference_source_pin,
    output range_select_oe,
    output reference_source_oe
  );
endinterface

// file: pas_link_monitor.sv
// Checker watching the converter to capture link
`timescale 1ns/1ns
module pas_link_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link signals
  input wire logic [pas_pkg::DATA_W-1:0] sample_word,
  input wire logic range_select_pin,
  input wire logic reference_source_pin,
  input wire logic range_select_oe,
  input wire logic reference_source_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_release;
    rst ##1 !rst;
  endsequence
  // Reset must park the word at mid scale, so no disable here
  chk_reset_mid_word: assert property (disable iff (1'b0)
    rst |=> sample_word == pas_pkg::CODE_MID)
    else $error("word not mid scale after reset");
  chk_release_word_held: assert property (disable iff (1'b0)
    s_release |-> sample_word == pas_pkg::CODE_MID)
    else $error("word moved before first edge");
  chk_range_pin_static: assert property (
    range_select_oe |=> $stable(range_select_pin))
    else $error("range pin changed while running");
  chk_ref_pin_static: assert property (
    reference_source_oe |=> $stable(reference_source_pin))
    else $error("reference pin changed while running");
  chk_range_oe_static: assert property (
    1'b1 |=> $stable(range_select_oe))
    else $error("range enable changed while running");
  chk_ref_oe_static: assert property (
    1'b1 |=> $stable(reference_source_oe))
    else $error("reference enable changed while running");
endmodule

// file: pas_pkg.sv
// Shared constants for the pipelined converter sample output link
package pas_pkg;
  localparam int DATA_W = 8;
  localparam int STAGE_COUNT = 6;
  localparam int LATENCY = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int RESID_W = 2;
  // Static pin levels
  localparam logic RANGE_2V = 1'b1;
  localparam logic RANGE_1V = 1'b0;
  localparam logic REF_EXTERNAL = 1'b1;
  localparam logic REF_INTERNAL = 1'b0;
  // Offset binary end points and mid scale
  localparam logic [DATA_W-1:0] CODE_NEG_FS = 8'h00;
  localparam logic [DATA_W-1:0] CODE_MID = 8'h80;
  localparam logic [DATA_W-1:0] CODE_POS_FS = 8'hFF;
endpackage

// file: tb_top.sv
// Self-checking bench for converter and capture ends
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  logic clock = 0;
  logic rst = 1;
  logic [7:0] sample_in = 8'h80;
  logic range_2v, ref_external, out_valid, overflow;
  logic out_ready = 0;
  logic [7:0] out_data;
  logic cfg_range_2v = 1, cfg_ref_external = 1, cfg_drive_en = 0;
  int n_fail = 0, check_count = 0;
  logic [7:0] hist[$], fifoq[$];
  logic ovf = 0;
  // Edges from a sample being taken to its word entering the buffer
  localparam int LAG = pas_pkg::LATENCY + 2;
  pas_link_if link ();
  pas_converter i_pas_converter (.clock(clock), .rst(rst),
    .sample_in(sample_in), .range_2v(range_2v),
    .ref_external(ref_external), .link(link));
  pas_capture i_pas_capture (.clock(clock), .rst(rst),
    .cfg_range_2v(cfg_range_2v), .cfg_ref_external(cfg_ref_external),
    .cfg_drive_en(cfg_drive_en), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .overflow(overflow),
    .link(link));
  pas_link_monitor i_pas_link_monitor (.clock(clock), .rst(rst),
    .sample_word(link.sample_word), .range_select_pin(link.range_select_pin),
    .reference_source_pin(link.reference_source_pin),
    .range_select_oe(link.range_select_oe),
    .reference_source_oe(link.reference_source_oe));
  initial forever #2 clock = ~clock;
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Config only moves under reset, keeping the pins static while running
  task automatic do_reset(int n, logic en, logic r, logic f);
    @(posedge clock);
    #1 rst = 1;
    cfg_drive_en = en;
    cfg_range_2v = r;
    cfg_ref_external = f;
    repeat (n) @(posedge clock);
    #1 rst = 0;
    hist.delete();
    fifoq.delete();
    ovf = 0;
  endtask
  // One cycle: log taken sample, check word and stream, drive next
  // Buffer model: full is judged before the pop, as a full buffer
  // refuses the word even when it drains at the same edge
  task automatic step(input logic [7:0] nxt, input logic rdy);
    bit full;
    @(posedge clock);
    full = (fifoq.size() == pas_pkg::FIFO_DEPTH);
    if (out_ready === 1'b1 && fifoq.size() > 0) begin
      void'(fifoq.pop_front());
    end
    if (hist.size() >= LAG) begin
      if (full) begin
        ovf = 1;
      end else begin
        fifoq.push_back(hist[hist.size()-LAG]);
      end
    end
    hist.push_back(sample_in);
    #1 out_ready = rdy;
    sample_in = nxt;
    if (hist.size() > pas_pkg::LATENCY)
      `CHK(link.sample_word, hist[hist.size()-5])
    `CHK(out_valid, fifoq.size() != 0)
    if (fifoq.size() != 0)
      `CHK(out_data, fifoq[0])
    `CHK(overflow, ovf)
  endtask
  initial begin
    void'($urandom(67109));
    for (int i = 0; i < 5; i++) begin
      do_reset(i == 0 ? 16 : 2, i != 0, i[0], i[1]);
      repeat (2) step(8'h80, 1);
      `CHK(range_2v, (i != 0) ? i[0] : 1'b1)
      `CHK(ref_external, (i != 0) ? i[1] : 1'b1)
      $display("config test %0d done", i);
    end
    step(8'h00, 1);
    step(8'hFF, 1);
    repeat (200) step(8'($urandom), $urandom_range(0, 3) != 0);
    $display("stream test done");
    // Fresh start so the sticky overflow is seen to clear and then set
    do_reset(2, 1, 1, 1);
    // Stall far past depth; the oldest sixteen words must survive
    repeat (30) step(8'($urandom), 0);
    `CHK(overflow, 1'b1)
    repeat (16) step(8'($urandom), 1);
    $display("overflow test done");
    conclude();
  end
endmodule
